// ---- logic/xbpl_pkg.sv ----
/*
 * Constants, register map and state encodings for the expansion bus pin logic.
 * Assumes a 32-bit classic Wishbone register bus and a single 250 MHz clock.
 */
// Summary of operation
// - The I/O space select to assert is decoded from word address bits 28 to 30.
// - At most one of the four space selects is ever asserted during an I/O access.
// - In host operation the four shared lane lines are byte enables from the host.
// - In I/O operation the device drives the four shared lane lines as low address bits.
// - The device drives separate I/O output-enable and read strobes during I/O reads.
// - One shared pin is the I/O write strobe in I/O mode and the host wait in host mode.
// - The address strobe marks the host address phase and may be released to high impedance.
// - The host control input picks the address or data register and the device routes to it.
// - The host read/write line is read with a polarity latched at reset.
// - The ready line is active-low from the device in host mode, active-high in I/O mode.
// - The burst-last line is read with a polarity latched at reset and marks the last transfer.
// - Hold request and hold grant lines arbitrate the bus; a grant hands over ownership.
// - The 32-bit data bus carries data and address, and sets configuration straps at reset.
package xbpl_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_IOADDR = 8'h04;
	localparam logic [7:0] REG_IOWDAT = 8'h08;
	localparam logic [7:0] REG_IOCMD  = 8'h0C;
	localparam logic [7:0] REG_IORDAT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_HPADDR = 8'h18;
	localparam logic [7:0] REG_HPDATA = 8'h1C;
	localparam logic [7:0] REG_RETRY  = 8'h20;

	localparam int CTRL_HOST_MODE = 0;
	localparam int CTRL_EXT_ARB   = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int CMD_START      = 0;
	localparam int CMD_WRITE      = 1;

	localparam int ST_BUSY        = 0;
	localparam int ST_DONE        = 1;
	localparam int ST_GRANTED     = 2;
	localparam int ST_HOST_PEND   = 3;
	localparam int ST_BURST_END   = 4;
	localparam int ST_DIR_POL     = 5;
	localparam int ST_FINAL_POL   = 6;
	localparam int ST_SYNC_HOST   = 7;

	// ------------------------------------------------------------------
	// Reset straps sampled from the data bus
	// ------------------------------------------------------------------
	localparam int STRAP_SYNC_HOST = 13;
	localparam int STRAP_DIR_POL   = 14;
	localparam int STRAP_FINAL_POL = 15;

	// ------------------------------------------------------------------
	// Space select decode and timing
	// ------------------------------------------------------------------
	localparam int SEL_HI_BIT     = 30;
	localparam int SEL_LO_BIT     = 28;
	localparam int IO_SETUP_CYC   = 2;
	localparam int IO_STROBE_MIN  = 4;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [5:0] {
		IO_IDLE    = 6'b000001,
		IO_REQ     = 6'b000010,
		IO_SETUP   = 6'b000100,
		IO_STROBE  = 6'b001000,
		IO_RECOVER = 6'b010000,
		IO_BACKOFF = 6'b100000
	} xbpl_io_state_e;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'b001,
		HS_WAIT  = 3'b010,
		HS_READY = 3'b100
	} xbpl_hs_state_e;

endpackage

// ---- logic/xbpl_top.sv ----
/*
 * Expansion bus pin logic: I/O port master, host port slave, hold arbitration
 * and Wishbone register file. Assumes all pin inputs are asynchronous to clock
 * and that a pad ring resolves the In/Out/Oe triples into wires.
 */
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module xbpl_top
	import xbpl_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [31:0] wbDatI,
	output logic      [31:0] wbDatO,
	input  wire logic        wbWe,
	input  wire logic [3:0]  wbSel,
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	output logic             wbAck,
	output logic      [3:0]  ioSpaceSelectN,
	output logic             ioportOutputEnableN,
	output logic             ioportReadStrobeN,
	output logic             ioportWriteOrHostWait,
	output logic             ioCtrlOe,
	input  wire logic [3:0]  laneEnableOrAddrIn,
	output logic      [3:0]  laneEnableOrAddrOut,
	output logic             laneEnableOrAddrOe,
	input  wire logic        hostportSelectInN,
	input  wire logic        hostportAddrStrobeNIn,
	output logic             hostportAddrStrobeNOut,
	output logic             hostportAddrStrobeNOe,
	input  wire logic        hostportRegSelect,
	input  wire logic        hostportDirIn,
	input  wire logic        hostportBurstFinalIn,
	input  wire logic        sharedReadyIn,
	output logic             sharedReadyOut,
	output logic             sharedReadyOe,
	input  wire logic        backoffIn,
	input  wire logic        busHoldRequestIn,
	output logic             busHoldRequestOut,
	output logic             busHoldRequestOe,
	input  wire logic        busHoldGrantIn,
	output logic             busHoldGrantOut,
	output logic             busHoldGrantOe,
	input  wire logic [31:0] expansionDataIn,
	output logic      [31:0] expansionDataOut,
	output logic             expansionDataOe,
	input  wire logic        hostSyncClockIn
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] spaceDecode(input logic [31:0] addr);
		logic [3:0] r;
		r = 4'h0;
		// Bit 30 qualifies the space, bits 29:28 pick one select: one-hot by construction
		if (addr[SEL_HI_BIT]) begin
			r[addr[SEL_HI_BIT-1:SEL_LO_BIT]] = 1'b1;
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam int SYNC_W = 46;
	logic [SYNC_W-1:0] syncA_q;
	logic [SYNC_W-1:0] syncB_q;

	always_ff @(posedge clock) begin
		syncA_q <= {hostSyncClockIn, hostportSelectInN, hostportAddrStrobeNIn, hostportRegSelect,
			hostportDirIn, hostportBurstFinalIn, sharedReadyIn, backoffIn, busHoldRequestIn,
			busHoldGrantIn, laneEnableOrAddrIn, expansionDataIn};
		syncB_q <= syncA_q;
	end

	logic        hostClkS;
	logic        selNS;
	logic        asNS;
	logic        regSelS;
	logic        dirS;
	logic        finalS;
	logic        readyS;
	logic        backoffS;
	logic        holdReqS;
	logic        holdGrantS;
	logic [3:0]  lanesS;
	logic [31:0] dataS;

	assign {hostClkS, selNS, asNS, regSelS, dirS, finalS, readyS, backoffS, holdReqS,
		holdGrantS, lanesS, dataS} = syncB_q;

	// ------------------------------------------------------------------
	// Reset straps
	// ------------------------------------------------------------------
	logic strapDone_q;
	logic dirWriteLevel_q;
	logic finalLevel_q;
	logic syncHost_q;
	logic hostClkPrev_q;
	logic hostQual;

	// Captured on the first edge after release; pulls still dominate the bus then
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			strapDone_q     <= 1'b0;
			dirWriteLevel_q <= 1'b0;
			finalLevel_q    <= 1'b0;
			syncHost_q      <= 1'b0;
		end else if (!strapDone_q) begin
			strapDone_q     <= 1'b1;
			dirWriteLevel_q <= dataS[STRAP_DIR_POL];
			finalLevel_q    <= dataS[STRAP_FINAL_POL];
			syncHost_q      <= dataS[STRAP_SYNC_HOST];
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hostClkPrev_q <= 1'b0;
		end else begin
			hostClkPrev_q <= hostClkS;
		end
	end

	// Synchronous host mode samples a new host access only on a rising host clock edge
	assign hostQual = syncHost_q ? (hostClkS & ~hostClkPrev_q) : 1'b1;

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [1:0]        ctrl_q;
	logic [31:0]       ioAddr_q;
	logic [31:0]       ioWdata_q;
	logic [31:0]       ioRdata_q;
	logic [31:0]       hpOutWord_q;
	logic              ioWrite_q;
	logic              startPending_q;
	logic              done_q;
	logic              wbHit;
	logic              wbWr;
	logic              wbRd;
	logic              hostMode;
	logic              extArb;
	xbpl_io_state_e    io_q;
	xbpl_hs_state_e    hs_q;
	logic              grant_q;
	logic              hostPend_q;
	logic              burstEnd_q;
	logic [31:0]       hpAddr_q;
	logic [31:0]       hpInWord_q;
	logic [CNT_W-1:0]  retry_q;
	logic              ioFinish;

	assign wbHit    = wbCyc & wbStb & ~wbAck;
	assign wbWr     = wbHit & wbWe;
	assign wbRd     = wbHit & ~wbWe;
	assign hostMode = ctrl_q[CTRL_HOST_MODE];
	assign extArb   = ctrl_q[CTRL_EXT_ARB];
	assign ioFinish = (io_q == IO_RECOVER);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wbAck <= 1'b0;
		end else begin
			wbAck <= wbHit;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl_q      <= CTRL_RESET;
			ioAddr_q    <= WORD_ZERO;
			ioWdata_q   <= WORD_ZERO;
			hpOutWord_q <= WORD_ZERO;
			ioWrite_q   <= 1'b0;
		end else if (wbWr) begin
			case (wbAdr)
				REG_CTRL: begin
					if (wbSel[0]) begin
						ctrl_q <= wbDatI[1:0];
					end
				end
				REG_IOADDR: ioAddr_q    <= laneMerge(ioAddr_q, wbDatI, wbSel);
				REG_IOWDAT: ioWdata_q   <= laneMerge(ioWdata_q, wbDatI, wbSel);
				REG_HPDATA: hpOutWord_q <= laneMerge(hpOutWord_q, wbDatI, wbSel);
				REG_IOCMD: begin
					if (wbSel[0] && io_q == IO_IDLE) begin
						ioWrite_q <= wbDatI[CMD_WRITE];
					end
				end
				default: ;
			endcase
		end
	end

	// Start is ignored while a cycle is already pending or running
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			startPending_q <= 1'b0;
		end else if (wbWr && wbAdr == REG_IOCMD && wbSel[0] && wbDatI[CMD_START]
			&& io_q == IO_IDLE) begin
			startPending_q <= 1'b1;
		end else if (io_q == IO_SETUP) begin
			startPending_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			done_q <= 1'b0;
		end else if (ioFinish) begin
			done_q <= 1'b1;
		end else if (startPending_q) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wbDatO <= WORD_ZERO;
		end else if (wbRd) begin
			case (wbAdr)
				REG_CTRL:   wbDatO <= {30'h0000_0000, ctrl_q};
				REG_IOADDR: wbDatO <= ioAddr_q;
				REG_IOWDAT: wbDatO <= ioWdata_q;
				REG_IOCMD:  wbDatO <= {30'h0000_0000, ioWrite_q, startPending_q};
				REG_IORDAT: wbDatO <= ioRdata_q;
				REG_STATUS: wbDatO <= {24'h00_0000, syncHost_q, finalLevel_q, dirWriteLevel_q,
					burstEnd_q, hostPend_q, grant_q, done_q, (io_q != IO_IDLE) | startPending_q};
				REG_HPADDR: wbDatO <= hpAddr_q;
				REG_HPDATA: wbDatO <= hpInWord_q;
				REG_RETRY:  wbDatO <= 32'(retry_q);
				default:    wbDatO <= WORD_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// I/O port master
	// ------------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			io_q    <= IO_IDLE;
			cnt_q   <= '0;
			retry_q <= '0;
		end else begin
			case (io_q)
				IO_IDLE: begin
					cnt_q <= '0;
					if (startPending_q && !hostMode && !grant_q) begin
						io_q <= extArb ? IO_REQ : IO_SETUP;
					end
				end
				IO_REQ: begin
					if (holdGrantS) begin
						io_q <= IO_SETUP;
					end
				end
				IO_SETUP: begin
					cnt_q <= cnt_q + 1'b1;
					if (backoffS) begin
						io_q <= IO_BACKOFF;
					end else if (cnt_q == CNT_W'(IO_SETUP_CYC - 1)) begin
						io_q  <= IO_STROBE;
						cnt_q <= '0;
					end
				end
				IO_STROBE: begin
					if (cnt_q != '1) begin
						cnt_q <= cnt_q + 1'b1;
					end
					if (backoffS) begin
						io_q <= IO_BACKOFF;
					end else if (cnt_q >= CNT_W'(IO_STROBE_MIN - 1) && readyS) begin
						io_q <= IO_RECOVER;
					end
				end
				IO_RECOVER: io_q <= IO_IDLE;
				IO_BACKOFF: begin
					cnt_q <= '0;
					if (!backoffS) begin
						io_q    <= extArb ? IO_REQ : IO_SETUP;
						retry_q <= retry_q + 1'b1;
					end
				end
				default: io_q <= IO_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ioRdata_q <= WORD_ZERO;
		end else if (io_q == IO_STROBE && !ioWrite_q && !backoffS && readyS
			&& cnt_q >= CNT_W'(IO_STROBE_MIN - 1)) begin
			ioRdata_q <= dataS;
		end
	end

	// ------------------------------------------------------------------
	// Hold arbitration
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			grant_q <= 1'b0;
		end else if (extArb || !holdReqS) begin
			grant_q <= 1'b0;
		end else if (io_q == IO_IDLE && !startPending_q) begin
			grant_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busHoldGrantOut   <= 1'b0;
			busHoldGrantOe    <= 1'b0;
			busHoldRequestOut <= 1'b0;
			busHoldRequestOe  <= 1'b0;
		end else begin
			busHoldGrantOut   <= grant_q;
			busHoldGrantOe    <= ~extArb;
			busHoldRequestOut <= extArb & (io_q != IO_IDLE) & (io_q != IO_BACKOFF);
			busHoldRequestOe  <= extArb;
		end
	end

	// ------------------------------------------------------------------
	// Host port slave
	// ------------------------------------------------------------------
	logic        hsSeen;
	logic        hsWriteNow;
	logic        hsIsData_q;
	logic        hsIsWrite_q;
	logic [3:0]  hsBe_q;
	logic [31:0] hsWord_q;
	logic        hostDataWr;

	assign hsSeen     = hostMode && hs_q == HS_IDLE && !selNS && !asNS && hostQual;
	assign hsWriteNow = (dirS == dirWriteLevel_q);
	assign hostDataWr = (hsSeen && hsWriteNow && regSelS && !hostPend_q)
		|| (hs_q == HS_WAIT && !hostPend_q);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hs_q        <= HS_IDLE;
			hsIsData_q  <= 1'b0;
			hsIsWrite_q <= 1'b0;
			hsBe_q      <= 4'h0;
			hsWord_q    <= WORD_ZERO;
			hpAddr_q    <= WORD_ZERO;
			hpInWord_q  <= WORD_ZERO;
		end else begin
			case (hs_q)
				HS_IDLE: begin
					if (hsSeen) begin
						hsIsData_q  <= regSelS;
						hsIsWrite_q <= hsWriteNow;
						hsBe_q      <= lanesS;
						hsWord_q    <= regSelS ? hpOutWord_q : hpAddr_q;
						if (hsWriteNow && !regSelS) begin
							hpAddr_q <= laneMerge(hpAddr_q, dataS, lanesS);
						end else if (regSelS && finalS != finalLevel_q) begin
							hpAddr_q <= hpAddr_q + 32'h0000_0004;
						end
						if (hostDataWr) begin
							hpInWord_q <= laneMerge(hpInWord_q, dataS, lanesS);
						end
						hs_q <= (hsWriteNow && regSelS && hostPend_q) ? HS_WAIT : HS_READY;
					end
				end
				HS_WAIT: begin
					// Software has not taken the last word yet; hold the host off
					if (!hostPend_q) begin
						hpInWord_q <= laneMerge(hpInWord_q, dataS, hsBe_q);
						hs_q       <= HS_READY;
					end
				end
				HS_READY: begin
					if (selNS) begin
						hs_q <= HS_IDLE;
					end
				end
				default: hs_q <= HS_IDLE;
			endcase
		end
	end

	// A new host word beats a software read in the same cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hostPend_q <= 1'b0;
		end else if (hostDataWr) begin
			hostPend_q <= 1'b1;
		end else if (wbRd && wbAdr == REG_HPDATA) begin
			hostPend_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			burstEnd_q <= 1'b0;
		end else if (hsSeen && regSelS && finalS == finalLevel_q) begin
			burstEnd_q <= 1'b1;
		end else if (wbRd && wbAdr == REG_STATUS) begin
			burstEnd_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	logic ioActive;
	logic ioStrobe;
	logic ownBus;

	assign ioActive = (io_q == IO_SETUP) || (io_q == IO_STROBE);
	assign ioStrobe = (io_q == IO_STROBE) && !backoffS;
	// Back-off and a granted hold both release every master pin
	assign ownBus   = !hostMode && !grant_q && (io_q != IO_BACKOFF) && !backoffS;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ioSpaceSelectN      <= 4'hF;
			ioportOutputEnableN <= 1'b1;
			ioportReadStrobeN   <= 1'b1;
			ioportWriteOrHostWait <= 1'b1;
			ioCtrlOe            <= 1'b0;
			laneEnableOrAddrOut <= 4'h0;
			laneEnableOrAddrOe  <= 1'b0;
		end else begin
			ioSpaceSelectN      <= (ioActive && ownBus) ? ~spaceDecode(ioAddr_q) : 4'hF;
			ioportOutputEnableN <= ~(ioStrobe && !ioWrite_q);
			ioportReadStrobeN   <= ~(ioStrobe && !ioWrite_q);
			if (hostMode) begin
				ioportWriteOrHostWait <= (hs_q == HS_WAIT);
			end else begin
				ioportWriteOrHostWait <= ~(ioStrobe && ioWrite_q);
			end
			ioCtrlOe            <= hostMode | ownBus;
			laneEnableOrAddrOut <= ioAddr_q[3:0];
			laneEnableOrAddrOe  <= ioActive && ownBus;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			expansionDataOut <= WORD_ZERO;
			expansionDataOe  <= 1'b0;
			sharedReadyOut   <= 1'b1;
			sharedReadyOe    <= 1'b0;
		end else begin
			if (hostMode) begin
				expansionDataOut <= hsWord_q;
				expansionDataOe  <= (hs_q == HS_READY) && !hsIsWrite_q && !selNS;
			end else begin
				expansionDataOut <= ioWdata_q;
				expansionDataOe  <= ioActive && ioWrite_q && ownBus;
			end
			sharedReadyOut <= ~(hs_q == HS_READY);
			sharedReadyOe  <= hostMode && (hs_q != HS_IDLE) && !selNS;
		end
	end

	// The device never masters the host port, so the address strobe stays released
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hostportAddrStrobeNOut <= 1'b1;
			hostportAddrStrobeNOe  <= 1'b0;
		end else begin
			hostportAddrStrobeNOut <= 1'b1;
			hostportAddrStrobeNOe  <= 1'b0;
		end
	end

endmodule

// ---- testbench/xbpl_asserts.sv ----
/*
 * Pin-level checker for the expansion bus pin logic; sees only its ports, one clock.
 */
`timescale 1ns/10ps
module xbpl_asserts (
	input logic       clock,
	input logic       reset_n,
	input logic       wbCyc,
	input logic       wbStb,
	input logic       wbAck,
	input logic [3:0] ioSpaceSelectN,
	input logic       ioportOutputEnableN,
	input logic       ioportReadStrobeN,
	input logic       ioportWriteOrHostWait,
	input logic       ioCtrlOe,
	input logic       laneEnableOrAddrOe,
	input logic       hostportSelectInN,
	input logic       hostportAddrStrobeNOe,
	input logic       sharedReadyOut,
	input logic       sharedReadyOe,
	input logic       backoffIn
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ----------------
	// Properties
	// ----------------
	sequence s_take; wbCyc && wbStb && !wbAck; endsequence
	sequence s_ackPulse; wbAck ##1 !wbAck; endsequence
	sequence s_boff; backoffIn [*5]; endsequence
	property p_ack; s_take |=> s_ackPulse; endproperty
	property p_oneSel; $countones(~ioSpaceSelectN) <= 1; endproperty
	property p_selDrv; ioSpaceSelectN != 4'hF |-> ioCtrlOe && laneEnableOrAddrOe; endproperty
	property p_rdPair;
		!ioportReadStrobeN |-> !ioportOutputEnableN && ioCtrlOe && laneEnableOrAddrOe;
	endproperty
	property p_wrRd; ioCtrlOe && !ioportWriteOrHostWait |-> ioportReadStrobeN; endproperty
	property p_asIdle; !hostportAddrStrobeNOe; endproperty
	property p_rdyLow;
		$rose(sharedReadyOe) |-> (!sharedReadyOut || ioportWriteOrHostWait)
			&& !$past(hostportSelectInN, 2);
	endproperty
	property p_rdyRel; hostportSelectInN [*4] |=> !sharedReadyOe; endproperty
	property p_backoff;
		s_boff |=> ioSpaceSelectN == 4'hF && !laneEnableOrAddrOe && ioportReadStrobeN;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a one-cycle answer");
	a_oneSel: assert property (p_oneSel) else $error("two space selects low");
	a_selDrv: assert property (p_selDrv) else $error("select without drive");
	a_rdPair: assert property (p_rdPair) else $error("read strobe pairing");
	a_wrRd: assert property (p_wrRd) else $error("write and read strobe");
	a_asIdle: assert property (p_asIdle) else $error("address strobe driven");
	a_rdyLow: assert property (p_rdyLow) else $error("host ready not low");
	a_rdyRel: assert property (p_rdyRel) else $error("ready held unselected");
	a_backoff: assert property (p_backoff) else $error("bus kept in back-off");
endmodule

bind xbpl_top xbpl_asserts u_xbpl_asserts (.clock, .reset_n, .wbCyc, .wbStb, .wbAck,
	.ioSpaceSelectN, .ioportOutputEnableN, .ioportReadStrobeN, .ioportWriteOrHostWait,
	.ioCtrlOe, .laneEnableOrAddrOe, .hostportSelectInN, .hostportAddrStrobeNOe,
	.sharedReadyOut, .sharedReadyOe, .backoffIn);

// ---- testbench/xbpl_peer.sv ----
/*
 * Far-side model: I/O peripheral, strap pulls, hold grantor, host data drive.
 * Assumes the bench resolves shared wires from the enables.
 */
`timescale 1ns/10ps
module xbpl_peer (
	input  logic        clock,
	input  logic        reset_n,
	input  logic        slow,
	input  logic        hostDrv,
	input  logic [31:0] hostWord,
	input  logic [31:0] strapWord,
	input  logic        ioportOutputEnableN,
	input  logic        ioportReadStrobeN,
	input  logic        ioportWriteOrHostWait,
	input  logic        ioCtrlOe,
	input  logic [3:0]  ioSpaceSelectN,
	input  logic [3:0]  laneAddr,
	input  logic        busHoldRequestOut,
	input  logic        busHoldRequestOe,
	output logic        sharedReadyIn,
	output logic        busHoldGrantIn,
	output logic [31:0] expansionDataIn
);
	logic [3:0]  lag_q;
	logic [3:0]  strap_q;
	logic [1:0]  grant_q;
	logic [31:0] last_q;
	// ----------------
	// Peer behaviour
	// ----------------
	always_ff @(posedge clock) begin
		if (ioportReadStrobeN && (ioportWriteOrHostWait || !ioCtrlOe))
			lag_q <= 4'h0;
		else if (lag_q != 4'hF)
			lag_q <= lag_q + 4'h1;
		// Straps stay on the bus past release so the synchronisers see them
		strap_q <= !reset_n ? 4'h0 : (strap_q == 4'h4 ? strap_q : strap_q + 4'h1);
		grant_q <= {grant_q[0], busHoldRequestOe && busHoldRequestOut};
		last_q <= expansionDataIn;
	end
	assign sharedReadyIn = lag_q >= (slow ? 4'h9 : 4'h1);
	assign busHoldGrantIn = grant_q[1];
	always_comb begin
		if (!reset_n || strap_q != 4'h4)
			expansionDataIn = strapWord;
		else if (hostDrv)
			expansionDataIn = hostWord;
		else if (!ioportOutputEnableN)
			expansionDataIn = {16'hBEE0, 8'h00, ~ioSpaceSelectN, laneAddr};
		else
			expansionDataIn = ~last_q; // Released bus toggles, never holds
	end
endmodule

// ---- testbench/tb_top.sv ----
/*
 * Self-checking bench for xbpl_top; assumes the peer model and the bound checker.
 */
`timescale 1ns/10ps
module tb_top;
	import xbpl_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
	logic backoffIn = 1'b0, slow = 1'b0, hostDrv = 1'b0, hostportSelectInN = 1'b1;
	logic hostportAddrStrobeNIn = 1'b1, hostportRegSelect = 1'b0, hostportDirIn = 1'b0;
	logic hostportBurstFinalIn = 1'b1;
	logic [7:0] wbAdr = 8'h00;
	logic [31:0] wbDatI = 32'h0, hostWord = 32'h0, wbDatO, expansionDataOut, peerData, q;
	logic wbAck, ioportOutputEnableN, ioportReadStrobeN, ioportWriteOrHostWait, ioCtrlOe;
	logic laneEnableOrAddrOe, sharedReadyOut, sharedReadyOe, peerRdy, busHoldGrantIn;
	logic hostportAddrStrobeNOe, busHoldRequestOut, busHoldRequestOe, expansionDataOe;
	logic [3:0] ioSpaceSelectN, laneEnableOrAddrOut;
	int miscompares = 0, numChecks = 0, r, t;
	logic [31:0] rA [5] = '{32'h4000_0005, 32'h5000_000A, 32'h6000_0003, 32'h7FFF_FFFF,
		32'h3000_0006};
	logic [3:0] rS [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};

	always #2 clock = ~clock;

	xbpl_top #(.CNT_W(8)) u_xbpl_top (.clock, .reset_n, .wbAdr, .wbDatI, .wbDatO, .wbWe,
		.wbSel(4'hF), .wbCyc, .wbStb, .wbAck, .ioSpaceSelectN, .ioportOutputEnableN,
		.ioportReadStrobeN, .ioportWriteOrHostWait, .ioCtrlOe, .laneEnableOrAddrOut,
		.laneEnableOrAddrIn(laneEnableOrAddrOe ? laneEnableOrAddrOut : 4'hF),
		.laneEnableOrAddrOe, .hostportSelectInN, .hostportAddrStrobeNIn,
		.hostportAddrStrobeNOut(), .hostportAddrStrobeNOe, .hostportRegSelect,
		.hostportDirIn, .hostportBurstFinalIn, .sharedReadyOut, .sharedReadyOe,
		.sharedReadyIn(sharedReadyOe ? sharedReadyOut : peerRdy), .backoffIn,
		.busHoldRequestIn(1'b0), .busHoldRequestOut, .busHoldRequestOe, .busHoldGrantIn,
		.busHoldGrantOut(), .busHoldGrantOe(), .expansionDataOut, .expansionDataOe,
		.expansionDataIn(expansionDataOe ? expansionDataOut : peerData),
		.hostSyncClockIn(1'b0));

	xbpl_peer u_xbpl_peer (.clock, .reset_n, .slow, .hostDrv, .hostWord,
		.strapWord(32'h0000_4000), .ioportOutputEnableN, .ioportReadStrobeN,
		.ioportWriteOrHostWait, .ioCtrlOe, .ioSpaceSelectN, .laneAddr(laneEnableOrAddrOut),
		.busHoldRequestOut, .busHoldRequestOe, .sharedReadyIn(peerRdy), .busHoldGrantIn,
		.expansionDataIn(peerData));

	// ----------------
	// Tasks
	// ----------------
	task automatic stopTest;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic tmo(input int i);
		if (i >= 99) begin
			miscompares++;
			$display("timeout at %0t", $time);
			stopTest();
		end
	endtask
	task automatic wbx(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		wbAdr <= a;
		wbWe <= w;
		wbDatI <= d;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		for (t = 0; t < 99 && wbAck !== 1'b1; t++)
			@(posedge clock);
		q = wbDatO;
		tmo(t);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wbx(a, 1'b0, 32'h0);
		chk(e, q);
	endtask
	task automatic ioAcc(input logic [31:0] a, input logic w);
		wbx(REG_IOADDR, 1'b1, a);
		wbx(REG_IOCMD, 1'b1, {30'h0, w, 1'b1});
	endtask
	task automatic ioStrobe;
		for (t = 0; t < 99 && ioportReadStrobeN && !(ioCtrlOe && !ioportWriteOrHostWait); t++)
			@(posedge clock);
		tmo(t);
	endtask
	task automatic ioIdle;
		int i;
		for (i = 0; i < 99; i++) begin
			wbx(REG_STATUS, 1'b0, 32'h0);
			if (q[ST_BUSY] === 1'b0) break;
		end
		tmo(i);
	endtask
	task automatic hAcc(input logic rs, input logic w, input logic fin, input logic [31:0] d);
		@(posedge clock);
		hostportRegSelect <= rs;
		hostportDirIn <= w;
		hostportBurstFinalIn <= fin;
		hostWord <= d;
		hostDrv <= w;
		hostportSelectInN <= 1'b0;
		hostportAddrStrobeNIn <= 1'b0;
		for (t = 0; t < 99 && !(sharedReadyOe === 1'b1 && sharedReadyOut === 1'b0); t++)
			@(posedge clock);
		tmo(t);
		if (!w) chk(d, expansionDataOut);
		hostportSelectInN <= 1'b1;
		hostportAddrStrobeNIn <= 1'b1;
		hostDrv <= 1'b0;
		for (t = 0; t < 99 && sharedReadyOe !== 1'b0; t++)
			@(posedge clock);
		tmo(t);
	endtask

	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rd(REG_CTRL, 32'h0);
		rd(REG_STATUS, 32'h1 << ST_DIR_POL);
		rd(8'h40, 32'h0);
		$display("reset test done");
		for (r = 0; r < 5; r++) begin
			slow <= r[0];
			ioAcc(rA[r], 1'b0);
			ioStrobe();
			chk(32'(rS[r]), 32'(ioSpaceSelectN));
			chk(32'(rA[r][3:0]), 32'(laneEnableOrAddrOut));
			ioIdle();
			rd(REG_IORDAT, {16'hBEE0, 8'h00, ~rS[r], rA[r][3:0]});
			$display("row %0d done", r);
		end
		wbx(REG_CTRL, 1'b1, 32'h2);
		wbx(REG_IOWDAT, 1'b1, 32'h89AB_CDEF);
		ioAcc(32'h5000_0004, 1'b1);
		for (r = 0; r < 99 && !(busHoldRequestOe && busHoldRequestOut); r++)
			@(posedge clock);
		tmo(r);
		chk(32'hF, 32'(ioSpaceSelectN));
		ioStrobe();
		chk(32'h89AB_CDEF, expansionDataOut);
		chk(32'h1, 32'(expansionDataOe));
		ioIdle();
		$display("hold write test done");
		wbx(REG_CTRL, 1'b1, 32'h0);
		ioAcc(32'h6000_0009, 1'b0);
		ioStrobe();
		backoffIn <= 1'b1;
		repeat (8) @(posedge clock);
		chk(32'hF, 32'(ioSpaceSelectN));
		chk(32'h0, 32'(ioCtrlOe));
		backoffIn <= 1'b0;
		ioStrobe();
		ioIdle();
		rd(REG_RETRY, 32'h1);
		rd(REG_IORDAT, {16'hBEE0, 8'h00, 4'h4, 4'h9});
		$display("back-off test done");
		wbx(REG_CTRL, 1'b1, 32'h1);
		wbx(REG_HPDATA, 1'b1, 32'hCAFE_0123);
		hAcc(1'b0, 1'b1, 1'b1, 32'h0000_0100);
		rd(REG_HPADDR, 32'h100);
		hAcc(1'b1, 1'b1, 1'b1, 32'h1357_9BDF);
		rd(REG_HPADDR, 32'h104);
		rd(REG_HPDATA, 32'h1357_9BDF);
		hAcc(1'b1, 1'b1, 1'b0, 32'h2468_ACE0);
		wbx(REG_STATUS, 1'b0, 32'h0);
		chk(32'h18, q & 32'h18);
		rd(REG_HPDATA, 32'h2468_ACE0);
		hAcc(1'b1, 1'b0, 1'b1, 32'hCAFE_0123);
		$display("host port test done");
		stopTest();
	end
endmodule
